// ---- rtl/twnv_pkg.sv ----
// constants shared by the two-wire memory slave and its byte array
// assumes nothing beyond a synthesis tool that understands packages
package twnv_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 9;
    localparam int CNT_W = 4;
    // bit counter: 0..7 are data bits, 8 is the acknowledge slot
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [8:0] ADDR_STEP = 9'h001;
    // slave address byte layout
    localparam int RW_BIT = 0;
    localparam int PAGE_BIT = 1;
    localparam int SEL_LO_BIT = 2;
    localparam int SEL_HI_BIT = 3;
    localparam int TYPE_LSB = 4;
    // value is arbitrary, override per system
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WORD,
        ST_WDATA,
        ST_RDATA
    } twnv_state_t;
endpackage : twnv_pkg

// ---- rtl/twnv_mem.sv ----
// byte array behind the two-wire slave, one write and one read port
// assumes the caller keeps both ports on the same clock edge
`timescale 1ns/100ps
module twnv_mem #(
    parameter int DW = twnv_pkg::DATA_W,
    parameter int AW = twnv_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic rd_en,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            cells[waddr] <= wdata;
        end
    end

    // registered read, so data is one edge behind the request
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rdata <= cells[raddr];
        end
    end
endmodule : twnv_mem

// ---- rtl/twnv_slave.sv ----
// two-wire serial slave front end of a 512 x 8 byte memory
// assumes scl_clk is the bus clock pin, sda_in the bus data level
// and that an external open-drain buffer resolves sda_out/sda_oe
//
// Summary of operation
// - stop is sda rising with scl high; every operation ends with it.
// - a stop seen mid-operation aborts that operation.
// - start is sda falling with scl high; every transfer opens with it.
// - a start anywhere aborts and awaits a fresh slave address byte.
// - ninth clock is acknowledge; sda high means no-ack, operation ends.
// - slave address upper nibble must equal the device type code.
// - address bits 3 and 2 must match the two select pins.
// - address bit 1 is the page bit, bit 0 is read/write.
// - on write, next byte is low address, latched with page bit.
// - read starts at latched low byte plus current page bit.
// - address increments before each data ack, wrapping 1ffh to 0.
// - bytes move most significant bit first both ways.
// - each received write data byte is acknowledged, any count.
// - array write after eighth bit; earlier start or stop writes nothing.
// - no busy time after a write; the next operation may follow.
// - protect high blocks writes, no ack, address counter held.
// - read sends eight bits then samples ack; no-ack ends the read.
// - write address plus word then repeated start gives random read.
// - sample sda on scl rising, change driven sda after scl falling.
`timescale 1ns/100ps
module twnv_slave #(
    parameter logic [3:0] DEV_TYPE = twnv_pkg::DEV_TYPE_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic select_pin_low,
    input wire logic select_pin_high,
    input wire logic write_protect,
    output logic link_busy,
    output logic byte_written,
    output logic byte_read
);
    localparam int DW = twnv_pkg::DATA_W;
    localparam int AW = twnv_pkg::ADDR_W;

    function automatic logic addr_match(
        input logic [7:0] b,
        input logic hi,
        input logic lo
    );
        addr_match = (b[7:twnv_pkg::TYPE_LSB] == DEV_TYPE)
            && (b[twnv_pkg::SEL_HI_BIT] == hi)
            && (b[twnv_pkg::SEL_LO_BIT] == lo);
    endfunction : addr_match

    // reset into the bus clock domain; takes effect on scl edges only
    logic rst_meta, link_rst;
    always_ff @(posedge scl_clk) begin
        rst_meta <= sys_rst;
        link_rst <= rst_meta;
    end

    // strap-like pins, synchronised on the bus clock
    logic [2:0] pin_meta;
    logic [2:0] pin_s;
    always_ff @(posedge scl_clk) begin
        pin_meta <= {write_protect, select_pin_high, select_pin_low};
        pin_s <= pin_meta;
    end
    logic wp_s, sel_hi_s, sel_lo_s;
    assign wp_s = pin_s[2];
    assign sel_hi_s = pin_s[1];
    assign sel_lo_s = pin_s[0];

    // start and stop are sda edges while scl high; they toggle here and
    // the scl logic compares. initial values stand in for power-on reset
    // since sda edges cannot be counted on while reset is applied.
    logic start_tog = 1'b0;
    logic stop_tog = 1'b0;
    always_ff @(negedge sda_in) begin
        if (scl_clk) begin
            start_tog <= ~start_tog;
        end
    end
    always_ff @(posedge sda_in) begin
        if (scl_clk) begin
            stop_tog <= ~stop_tog;
        end
    end

    // the toggles settle while scl is high, a half period before the
    // next rising edge reads them, so no extra stages are needed here
    logic start_seen, stop_seen, start_pend, stop_pend, active;
    assign start_pend = start_tog ^ start_seen;
    assign stop_pend = stop_tog ^ stop_seen;
    assign active = !start_pend && !stop_pend;

    always_ff @(posedge scl_clk) begin
        start_seen <= start_tog;
        stop_seen <= stop_tog;
    end

    twnv_pkg::twnv_state_t state;
    logic [3:0] cnt;
    logic ack_go;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [8:0] addr;
    logic [8:0] addr_next;
    logic [7:0] rx_byte;
    logic [7:0] rdata;
    logic last_bit, ack_slot, addr_hit, rd_en;
    logic word_fire, wr_fire, rd_step, inc_fire;
    logic [8:0] rd_addr;

    // incoming bits sampled on the rising edge, msb first
    assign rx_byte = {shreg[6:0], sda_in};
    assign last_bit = (cnt == twnv_pkg::CNT_LAST);
    assign ack_slot = (cnt == twnv_pkg::CNT_ACK);
    assign addr_next = addr + twnv_pkg::ADDR_STEP;

    assign addr_hit = active && (state == twnv_pkg::ST_ADDR) && last_bit
        && addr_match(rx_byte, sel_hi_s, sel_lo_s);
    assign word_fire = active && (state == twnv_pkg::ST_WORD) && last_bit;
    // write lands on the eighth bit edge, before the ack is driven
    assign wr_fire = active && (state == twnv_pkg::ST_WDATA) && last_bit
        && !wp_s;
    assign rd_step = active && (state == twnv_pkg::ST_RDATA) && last_bit;
    assign inc_fire = wr_fire || rd_step;

    // prefetch: first byte at address match, next at each byte's end
    assign rd_en = (addr_hit && rx_byte[twnv_pkg::RW_BIT]) || rd_step;
    assign rd_addr = rd_step ? addr_next
        : {rx_byte[twnv_pkg::PAGE_BIT], addr[7:0]};

    // bit counter, state and acknowledge decision
    always_ff @(posedge scl_clk) begin
        if (link_rst) begin
            state <= twnv_pkg::ST_IDLE;
            cnt <= twnv_pkg::CNT_RST;
            ack_go <= 1'b0;
        end else if (start_pend) begin
            // this edge already carried the first address bit
            state <= twnv_pkg::ST_ADDR;
            cnt <= twnv_pkg::CNT_FIRST;
            ack_go <= 1'b0;
        end else if (stop_pend) begin
            state <= twnv_pkg::ST_IDLE;
            cnt <= twnv_pkg::CNT_RST;
            ack_go <= 1'b0;
        end else if (state == twnv_pkg::ST_IDLE) begin
            cnt <= twnv_pkg::CNT_RST;
            ack_go <= 1'b0;
        end else if (!ack_slot) begin
            cnt <= cnt + 4'h1;
            if (last_bit) begin
                case (state)
                    twnv_pkg::ST_ADDR: ack_go <= addr_hit;
                    twnv_pkg::ST_WORD: ack_go <= 1'b1;
                    twnv_pkg::ST_WDATA: ack_go <= !wp_s;
                    default: ack_go <= 1'b0;
                endcase
            end
        end else begin
            cnt <= twnv_pkg::CNT_RST;
            ack_go <= 1'b0;
            case (state)
                twnv_pkg::ST_ADDR: begin
                    if (!ack_go) begin
                        state <= twnv_pkg::ST_IDLE;
                    end else if (shreg[twnv_pkg::RW_BIT]) begin
                        state <= twnv_pkg::ST_RDATA;
                    end else begin
                        state <= twnv_pkg::ST_WORD;
                    end
                end
                twnv_pkg::ST_WORD: state <= twnv_pkg::ST_WDATA;
                twnv_pkg::ST_WDATA: begin
                    // protect refusal ends the operation like a no-ack
                    if (!ack_go) begin
                        state <= twnv_pkg::ST_IDLE;
                    end
                end
                twnv_pkg::ST_RDATA: begin
                    if (sda_in) begin
                        state <= twnv_pkg::ST_IDLE;
                    end
                end
                default: state <= twnv_pkg::ST_IDLE;
            endcase
        end
    end

    // receive shifter; runs on every data bit, idle or not
    always_ff @(posedge scl_clk) begin
        if (link_rst) begin
            shreg <= 8'h00;
        end else if (start_pend || !ack_slot) begin
            shreg <= rx_byte;
        end
    end

    // transmit shifter: loaded at the ack slot, msb leaves first
    always_ff @(posedge scl_clk) begin
        if (link_rst) begin
            tx <= 8'h00;
        end else if (!active) begin
            tx <= 8'h00;
        end else if (ack_slot && ((state == twnv_pkg::ST_ADDR && ack_go
            && shreg[twnv_pkg::RW_BIT])
            || (state == twnv_pkg::ST_RDATA && !sda_in))) begin
            tx <= rdata;
        end else if (state == twnv_pkg::ST_RDATA && !ack_slot) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    // address latch with page bit and auto-increment
    always_ff @(posedge scl_clk) begin
        if (link_rst) begin
            addr <= twnv_pkg::ADDR_RST;
        end else if (addr_hit) begin
            addr[8] <= rx_byte[twnv_pkg::PAGE_BIT];
        end else if (word_fire) begin
            addr <= {addr[8], rx_byte};
        end else if (inc_fire) begin
            addr <= addr_next;
        end
    end

    // the array finishes within the same edge, so there is no busy time
    twnv_mem #(
        .DW(DW),
        .AW(AW)
    ) u_mem (
        .clk(scl_clk),
        .wr_en(wr_fire),
        .waddr(addr),
        .wdata(rx_byte),
        .rd_en(rd_en),
        .raddr(rd_addr),
        .rdata(rdata)
    );

    // sda changes only after scl falls; a pending start or stop
    // releases the line so a repeated start never meets our drive
    always_ff @(negedge scl_clk) begin
        if (link_rst || !active) begin
            sda_oe <= 1'b0;
        end else if (ack_slot && ack_go
            && state != twnv_pkg::ST_RDATA) begin
            sda_oe <= 1'b1;
        end else if (state == twnv_pkg::ST_RDATA && !ack_slot) begin
            sda_oe <= !tx[7];
        end else begin
            sda_oe <= 1'b0;
        end
    end

    // open drain: the pin only ever pulls low
    always_ff @(posedge clk) begin
        sda_out <= 1'b0;
    end

    // event toggles for the system clock side
    logic wr_tog, rd_tog;
    always_ff @(posedge scl_clk) begin
        if (link_rst) begin
            wr_tog <= 1'b0;
            rd_tog <= 1'b0;
        end else begin
            wr_tog <= wr_tog ^ wr_fire;
            rd_tog <= rd_tog ^ rd_step;
        end
    end

    // system side: two-stage synchronisers plus an edge stage per event
    logic [3:0] ev_meta, ev_sync, ev_last, ev_edge;
    assign ev_edge = ev_sync ^ ev_last;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ev_meta <= 4'h0;
            ev_sync <= 4'h0;
            ev_last <= 4'h0;
        end else begin
            ev_meta <= {rd_tog, wr_tog, stop_tog, start_tog};
            ev_sync <= ev_meta;
            ev_last <= ev_sync;
        end
    end

    // busy follows start and stop directly, since scl may halt after
    // a stop and the bus-side state would not show the end in time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_busy <= 1'b0;
        end else if (ev_edge[0]) begin
            link_busy <= 1'b1;
        end else if (ev_edge[1]) begin
            link_busy <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byte_written <= 1'b0;
            byte_read <= 1'b0;
        end else begin
            byte_written <= ev_edge[2];
            byte_read <= ev_edge[3];
        end
    end

    chk_start_abort: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        start_pend |=> (state == twnv_pkg::ST_ADDR)
            && (cnt == twnv_pkg::CNT_FIRST)
    ) else $error("start did not restart address phase");
    chk_stop_idle: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (stop_pend && !start_pend) |=> (state == twnv_pkg::ST_IDLE)
    ) else $error("stop did not abort operation");
    chk_addr_wrap: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (inc_fire && addr == 9'h1ff) |=> (addr == 9'h000)
    ) else $error("address did not wrap to zero");
    chk_protect_hold: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (active && state == twnv_pkg::ST_WDATA && last_bit && wp_s)
            |=> $stable(addr) && !ack_go ##1 (state == twnv_pkg::ST_IDLE)
    ) else $error("protected write changed address or acked");
    chk_type_reject: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (active && state == twnv_pkg::ST_ADDR && last_bit
            && rx_byte[7:4] != DEV_TYPE)
            |=> !ack_go ##1 (state == twnv_pkg::ST_IDLE)
    ) else $error("foreign device type acknowledged");
    chk_data_ack: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (wr_fire && !stop_pend) ##1 (active && ack_slot) |-> sda_oe
    ) else $error("write data byte not acknowledged");
    chk_read_nack: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (active && state == twnv_pkg::ST_RDATA && ack_slot && sda_in)
            |=> (state == twnv_pkg::ST_IDLE)
    ) else $error("read continued after no-ack");
    chk_idle_release: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (state == twnv_pkg::ST_IDLE
            && $past(state) == twnv_pkg::ST_IDLE) |-> !sda_oe
    ) else $error("sda driven while idle");
    // the stored byte must already stand in the array at the ack edge
    chk_write_slot: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        wr_fire |=> ack_slot
            && (u_mem.cells[$past(addr)] == $past(rx_byte))
    ) else $error("array write not complete before ack");
endmodule : twnv_slave

// ---- verification/twnv_master.sv ----
// behavioural two-wire bus master that drives the slave's bus clock
// assumes a pull-up on the data wire; sda_low high pulls it down
`timescale 1ns/100ps
module twnv_master (
    output logic scl_clk,
    output logic sda_low,
    input wire logic sda_wire
);
    localparam time QTR = 40;
    // bus clock stands high between frames, data released
    initial begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end
    // data set while clock low, held over the high phase
    task automatic pulse(input logic bit_low, output logic seen);
        #QTR;
        sda_low = bit_low;
        #QTR;
        scl_clk = 1'b1;
        #QTR;
        seen = sda_wire;
        #QTR;
        scl_clk = 1'b0;
    endtask : pulse
    // clock cycles with data released, used only around reset
    task automatic idle_clocks(input int n);
        repeat (n) begin
            scl_clk = 1'b0;
            #(2*QTR);
            scl_clk = 1'b1;
            #(2*QTR);
        end
    endtask : idle_clocks
    // data falls while clock high, also as repeated start
    task automatic send_start;
        #QTR;
        sda_low = 1'b0;
        #QTR;
        scl_clk = 1'b1;
        #QTR;
        sda_low = 1'b1;
        #QTR;
        scl_clk = 1'b0;
    endtask : send_start
    // data rises while clock high; master owns data here
    task automatic send_stop;
        #QTR;
        sda_low = 1'b1;
        #QTR;
        scl_clk = 1'b1;
        #QTR;
        sda_low = 1'b0;
        #(2*QTR);
    endtask : send_stop
    task automatic send_bits(input logic [7:0] d, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            pulse(!d[i], s);
        end
    endtask : send_bits
    // ninth clock with data released, device pulls low to accept
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        send_bits(d, 8);
        pulse(1'b0, s);
        ack = (s === 1'b0);
    endtask : write_byte
    // last byte wanted is answered with no-ack
    task automatic read_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, d[i]);
        end
        pulse(give_ack, s);
    endtask : read_byte
endmodule : twnv_master

// ---- verification/test_twnv_slave.sv ----
// self-checking bench for the two-wire memory slave
// assumes the behavioural master model drives the bus clock
`timescale 1ns/100ps
module test_twnv_slave;
    // type nibble value is arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h5;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl_clk, sda_low, sda_wire, sda_out, sda_oe;
    logic sel_lo = 1'b0;
    logic sel_hi = 1'b1;
    logic write_protect = 1'b0;
    logic link_busy, byte_written, byte_read;
    int fail_count = 0;
    int total_checks = 0;
    int wr_seen = 0;
    int rd_seen = 0;
    // pull-up: wire is low while either party pulls it
    assign sda_wire = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    twnv_slave #(.DEV_TYPE(TYPE_CODE)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .scl_clk(scl_clk),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .select_pin_low(sel_lo), .select_pin_high(sel_hi),
        .write_protect(write_protect), .link_busy(link_busy),
        .byte_written(byte_written), .byte_read(byte_read)
    );
    twnv_master model_u (
        .scl_clk(scl_clk), .sda_low(sda_low), .sda_wire(sda_wire)
    );
    initial begin
        forever #50 clk = ~clk;
    end
    // sampled on the falling edge, away from the edge that launches them
    always @(negedge clk) begin
        if (byte_written === 1'b1) wr_seen++;
        if (byte_read === 1'b1) rd_seen++;
    end
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] slv(input logic page, input logic rd);
        return {TYPE_CODE, sel_hi, sel_lo, page, rd};
    endfunction : slv
    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic ack;
        model_u.write_byte(d, ack);
        check("ack", {15'h0, ack}, {15'h0, exp_ack});
    endtask : wb
    task automatic rb(input logic give_ack, input logic [7:0] exp);
        logic [7:0] d;
        model_u.read_byte(give_ack, d);
        check("read data", {8'h0, d}, {8'h0, exp});
    endtask : rb
    task automatic stop_settle;
        model_u.send_stop();
        repeat (8) @(negedge clk);
        check("busy after stop", {15'h0, link_busy}, 16'h0);
    endtask : stop_settle
    task automatic t_write_wrap;
        wr_seen = 0;
        model_u.send_start();
        wb(slv(1'b1, 1'b0), 1'b1);
        check("busy in frame", {15'h0, link_busy}, 16'h1);
        wb(8'hfe, 1'b1);
        wb(8'ha1, 1'b1);
        wb(8'hb2, 1'b1);
        wb(8'hc3, 1'b1);
        wb(8'hd4, 1'b1);
        stop_settle();
        check("bytes written", 16'(wr_seen), 16'h4);
    endtask : t_write_wrap
    // follows a write with no gap, so no busy time is tolerated
    task automatic t_selective_read;
        rd_seen = 0;
        model_u.send_start();
        wb(slv(1'b1, 1'b0), 1'b1);
        wb(8'hfe, 1'b1);
        model_u.send_start();
        wb(slv(1'b1, 1'b1), 1'b1);
        rb(1'b1, 8'ha1);
        rb(1'b1, 8'hb2);
        rb(1'b0, 8'hc3);
        stop_settle();
        check("bytes read", 16'(rd_seen), 16'h3);
        model_u.send_start();
        wb(slv(1'b0, 1'b1), 1'b1);
        rb(1'b0, 8'hd4);
        stop_settle();
    endtask : t_selective_read
    task automatic t_select;
        for (int k = 0; k < 4; k++) begin
            model_u.send_start();
            wb({TYPE_CODE, 2'(k), 2'b00}, k == 2);
            stop_settle();
        end
        model_u.send_start();
        wb({TYPE_CODE ^ 4'h8, sel_hi, sel_lo, 2'b00}, 1'b0);
        stop_settle();
    endtask : t_select
    task automatic t_protect;
        wr_seen = 0;
        @(negedge clk);
        write_protect = 1'b1;
        model_u.send_start();
        wb(slv(1'b1, 1'b0), 1'b1);
        wb(8'hff, 1'b1);
        wb(8'h00, 1'b0);
        stop_settle();
        @(negedge clk);
        write_protect = 1'b0;
        model_u.send_start();
        wb(slv(1'b1, 1'b1), 1'b1);
        rb(1'b0, 8'hb2);
        stop_settle();
        check("protected writes", 16'(wr_seen), 16'h0);
    endtask : t_protect
    // partial bytes cut by start, then by stop, must write nothing
    task automatic t_abort;
        wr_seen = 0;
        model_u.send_start();
        wb(slv(1'b0, 1'b0), 1'b1);
        wb(8'h01, 1'b1);
        model_u.send_bits(8'h55, 5);
        model_u.send_start();
        wb(slv(1'b0, 1'b1), 1'b1);
        rb(1'b0, 8'hd4);
        stop_settle();
        model_u.send_start();
        wb(slv(1'b0, 1'b0), 1'b1);
        wb(8'h01, 1'b1);
        // the stop's own clock carries the seventh bit, so no eighth comes
        model_u.send_bits(8'h0f, 6);
        stop_settle();
        model_u.send_start();
        wb(slv(1'b0, 1'b1), 1'b1);
        rb(1'b0, 8'hd4);
        stop_settle();
        check("aborted writes", 16'(wr_seen), 16'h0);
    endtask : t_abort
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // whole sequence needs well under 200 us of bus time
    initial begin
        #1_000_000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (3) @(negedge clk);
        model_u.idle_clocks(3);
        @(negedge clk);
        sys_rst = 1'b0;
        model_u.idle_clocks(2);
        check("oe after reset", {15'h0, sda_oe}, 16'h0);
        check("busy after reset", {15'h0, link_busy}, 16'h0);
        check("sda pull value", {15'h0, sda_out}, 16'h0);
        t_write_wrap();
        t_selective_read();
        t_select();
        t_protect();
        t_abort();
        complete_run();
    end
endmodule : test_twnv_slave
